// >>> logic/fbm_host.sv
/*
 * Host controller that drives a parallel flash through its bus pins.
 * Assumes the flash pins are synchronous to clk and the data bus is
 * resolved outside from dq_out, dq_oe and the flash drive.
 */
`timescale 1ns/1ps
module fbm_host
    import fbm_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      req_valid,
    output logic                           req_ready,
    input  wire fbm_pkg::fbm_req_t         req_kind,
    input  wire logic [fbm_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [fbm_pkg::DATA_W-1:0] req_data,
    input  wire logic                      boot_unlock_req,
    output logic                           rsp_valid,
    output logic [fbm_pkg::DATA_W-1:0]     rsp_data,
    output fbm_pkg::fbm_pins_t             pins,
    output logic                           boot_unlock_level,
    output logic                           identifier_probe_level,
    output logic [fbm_pkg::DATA_W-1:0]     dq_out,
    output logic                           dq_oe,
    input  wire logic [fbm_pkg::DATA_W-1:0] dq_in
);
    import fbm_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WRITE,
        ST_GAP,
        ST_READ,
        ST_DONE
    } fbm_state_t;

    fbm_state_t         state_q, state_d;
    logic [CNT_W-1:0]   cnt_q;
    logic [1:0]         phase_q;
    fbm_req_t           kind_q;
    logic [ADDR_W-1:0]  addr_q;
    logic [DATA_W-1:0]  data_q;
    logic [DATA_W-1:0]  rsp_q;
    logic               rsp_vq;
    logic               pd_n_q;

    // ****************************************
    // Sequence decode
    // ****************************************
    wire two_writes = (kind_q == REQ_PROGRAM) || (kind_q == REQ_ERASE);
    wire read_kind  = (kind_q == REQ_READ) || (kind_q == REQ_IDENT) || (kind_q == REQ_PROBE_ID);
    wire cnt_done   = (cnt_q == '0);
    wire [7:0] first_byte = (kind_q == REQ_PROGRAM) ? CMD_PROG_SET :
                            (kind_q == REQ_ERASE)   ? CMD_ERASE_SET :
                            (kind_q == REQ_IDENT)   ? CMD_IDENT : data_q[7:0];
    wire [7:0] second_byte = (kind_q == REQ_ERASE) ? CMD_CONFIRM : data_q[7:0];
    wire [DATA_W-1:0] wr_word = (phase_q == 2'd0) ? {8'h00, first_byte}
                              : (kind_q == REQ_PROGRAM) ? data_q : {8'h00, second_byte};
    // Identifier reads keep upper address bits low
    wire [ADDR_W-1:0] bus_addr = (kind_q == REQ_IDENT || kind_q == REQ_PROBE_ID)
                                 ? {{(ADDR_W-1){1'b0}}, addr_q[0]} : addr_q;
    wire want_more_write = two_writes && (phase_q == 2'd0);
    wire writing = (state_q == ST_WRITE);
    wire reading = (state_q == ST_READ);

    assign req_ready = (state_q == ST_IDLE);
    assign rsp_valid = rsp_vq;
    assign rsp_data  = rsp_q;

    // ****************************************
    // Pin drive
    // ****************************************
    assign pins.powerdown_reset_n = pd_n_q;
    assign pins.chip_sel_n = !(writing || reading);
    assign pins.out_en_n   = !reading;
    assign pins.write_n    = !writing;
    assign pins.probe_a9   = reading && (kind_q == REQ_PROBE_ID);
    assign pins.addr       = bus_addr;
    assign identifier_probe_level = pins.probe_a9;
    assign boot_unlock_level = boot_unlock_req && pd_n_q;
    // Host drives data only while writing, never with output enable low
    assign dq_oe  = writing;
    assign dq_out = wr_word;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:  if (req_valid && pd_n_q) state_d = (req_kind == REQ_READ || req_kind == REQ_PROBE_ID)
                                                          ? ST_READ : ST_WRITE;
            ST_WRITE: if (cnt_done) state_d = ST_GAP;
            ST_GAP:   if (want_more_write) state_d = ST_WRITE;
                      else if (read_kind) state_d = ST_READ;
                      else state_d = ST_DONE;
            ST_READ:  if (cnt_done) state_d = ST_DONE;
            ST_DONE:  state_d = ST_IDLE;
            default:  state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            pd_n_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            pd_n_q  <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q   <= '0;
            phase_q <= 2'd0;
            kind_q  <= REQ_READ;
            addr_q  <= '0;
            data_q  <= '0;
        end else if (state_q == ST_IDLE && state_d != ST_IDLE) begin
            kind_q  <= req_kind;
            addr_q  <= req_addr;
            data_q  <= req_data;
            phase_q <= 2'd0;
            cnt_q   <= (state_d == ST_READ) ? CNT_W'(ACCESS_CYC - 1) : CNT_W'(WRITE_CYC - 1);
        end else if (state_q == ST_GAP) begin
            phase_q <= want_more_write ? 2'd1 : phase_q;
            cnt_q   <= (state_d == ST_READ) ? CNT_W'(ACCESS_CYC - 1) : CNT_W'(WRITE_CYC - 1);
        end else if (!cnt_done) begin
            cnt_q <= cnt_q - CNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_q  <= '0;
            rsp_vq <= 1'b0;
        end else begin
            rsp_vq <= (state_q == ST_DONE);
            if (reading && cnt_done) begin
                rsp_q <= dq_in;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_no_contention: assert property (@(posedge clk) disable iff (rst) dq_oe |-> pins.out_en_n)
        else $error("Host drives data while output enable low");

    a_write_strobe_only: assert property (@(posedge clk) disable iff (rst)
        !pins.write_n |-> !pins.chip_sel_n && pins.out_en_n && dq_oe)
        else $error("Write strobe without select or data");

    a_strobe_exclusive: assert property (@(posedge clk) disable iff (rst)
        pins.out_en_n || pins.write_n)
        else $error("Output enable and write strobe low together");

    a_id_addr_low: assert property (@(posedge clk) disable iff (rst)
        (reading && kind_q == REQ_IDENT) |-> (pins.addr[ADDR_W-1:1] == '0))
        else $error("Identifier read with upper address set");

    a_ident_command: assert property (@(posedge clk) disable iff (rst)
        (writing && kind_q == REQ_IDENT) |-> (dq_out == {8'h00, CMD_IDENT}))
        else $error("Identifier sequence without identifier command");

    a_erase_confirm: assert property (@(posedge clk) disable iff (rst)
        (writing && kind_q == REQ_ERASE && phase_q == 2'd1) |-> dq_out[7:0] == CMD_CONFIRM)
        else $error("Erase second write is not confirm");

    a_cmd_upper_zero: assert property (@(posedge clk) disable iff (rst)
        (writing && (kind_q != REQ_PROGRAM || phase_q == 2'd0)) |-> (dq_out[15:8] == 8'h00))
        else $error("Command write with upper byte set");

    a_probe_read_only: assert property (@(posedge clk) disable iff (rst)
        pins.probe_a9 |-> (!pins.out_en_n && pins.write_n && !dq_oe))
        else $error("Address nine probe outside a read");

    a_powerdown_idle: assert property (@(posedge clk) disable iff (rst)
        !pins.powerdown_reset_n |-> (pins.chip_sel_n && pins.write_n && pins.out_en_n && !dq_oe))
        else $error("Bus active while powerdown low");

    a_unlock_gate: assert property (@(posedge clk) disable iff (rst)
        boot_unlock_level |-> pins.powerdown_reset_n)
        else $error("Unlock level while powerdown low");

    // ****************************************
    // Bus timing checks
    // ****************************************
    a_read_length: assert property (@(posedge clk) disable iff (rst)
        $rose(reading) |-> reading [*8] ##1 !reading)
        else $error("Read strobe length wrong");

    a_write_length: assert property (@(posedge clk) disable iff (rst)
        $rose(writing) |-> writing [*3] ##1 !writing)
        else $error("Write strobe length wrong");

    a_read_capture: assert property (@(posedge clk) disable iff (rst)
        (reading && cnt_done) |=> (rsp_data == $past(dq_in)))
        else $error("Read data not captured on last read cycle");

    a_done_answer: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_DONE) |=> rsp_valid)
        else $error("No response after sequence end");

    a_rsp_pulse: assert property (@(posedge clk) disable iff (rst)
        rsp_valid |=> !rsp_valid)
        else $error("Response valid longer than one cycle");
endmodule : fbm_host

// >>> logic/fbm_pkg.sv
/*
 * Package for the flash bus-mode host controller: command codes, pin bundle,
 * user request kinds and bus timing counts.
 * Assumes a 50 MHz system clock and a flash device on an asynchronous bus.
 */
package fbm_pkg;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned ACCESS_NS     = 150;
    localparam int unsigned WRITE_NS      = 60;
    localparam int unsigned ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WRITE_CYC     = (WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W         = 4;

    localparam int unsigned ADDR_W = 18;
    localparam int unsigned DATA_W = 16;

    localparam logic [7:0] CMD_INVALID   = 8'h00;
    localparam logic [7:0] CMD_PROG_ALT  = 8'h10;
    localparam logic [7:0] CMD_ERASE_SET = 8'h20;
    localparam logic [7:0] CMD_PROG_SET  = 8'h40;
    localparam logic [7:0] CMD_CLR_STAT  = 8'h50;
    localparam logic [7:0] CMD_RD_STAT   = 8'h70;
    localparam logic [7:0] CMD_IDENT     = 8'h90;
    localparam logic [7:0] CMD_SUSPEND   = 8'hB0;
    localparam logic [7:0] CMD_CONFIRM   = 8'hD0;
    localparam logic [7:0] CMD_RD_ARRAY  = 8'hFF;

    localparam logic [ADDR_W-1:0] ID_MFR_ADDR = 18'h0_0000;
    localparam logic [ADDR_W-1:0] ID_DEV_ADDR = 18'h0_0001;

    localparam int unsigned SR_READY_BIT = 7;
    localparam int unsigned SR_ERASE_BIT = 5;
    localparam int unsigned SR_PROG_BIT  = 4;

    typedef enum logic [2:0] {
        REQ_READ,
        REQ_CMD,
        REQ_PROGRAM,
        REQ_ERASE,
        REQ_IDENT,
        REQ_PROBE_ID
    } fbm_req_t;

    typedef struct packed {
        logic              powerdown_reset_n;
        logic              chip_sel_n;
        logic              out_en_n;
        logic              write_n;
        logic              probe_a9;
        logic [ADDR_W-1:0] addr;
    } fbm_pins_t;
endpackage : fbm_pkg

// >>> sim/fbm_flash_model.sv
/* Behavioural flash device seen by the host controller.
   Assumes pins change on rising clk edges; clk samples writes and latches the last bus value into held. */
`timescale 1ns/1ps
module fbm_flash_model
    import fbm_pkg::*;
#(
    parameter logic [15:0] MFR_CODE  = 16'h00A5, // Arbitrary value
    parameter logic [15:0] DEV_CODE  = 16'h00C3, // Arbitrary value
    parameter logic [17:0] BOOT_LAST = 18'h0_1FFF
)(
    input  wire logic               clk,
    input  wire fbm_pkg::fbm_pins_t pins,
    input  wire logic [15:0]        dq_out,
    input  wire logic               dq_oe,
    input  wire logic               boot_unlock_level,
    input  wire logic               identifier_probe_level,
    input  wire logic               program_supply_high,
    output logic [15:0]             dq_in
);
    // ****************
    // Read path
    // ****************
    logic [15:0] mem [logic [17:0]];
    logic [1:0]  mode = 2'd0, pend = 2'd0;
    logic [7:0]  sr = 8'h80; // Ready bit always set
    logic [15:0] wd, held, rd;
    logic [17:0] wa;
    logic        wr = 1'b0, lock;
    wire drv = pins.powerdown_reset_n && !pins.chip_sel_n && !pins.out_en_n;
    always @* begin
        // Word width only; codes keep upper byte zero so byte reads match
        if (mode == 2'd1 || identifier_probe_level) rd = pins.addr[0] ? DEV_CODE : MFR_CODE;
        else if (mode == 2'd2) rd = {8'h00, sr};
        else rd = mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF;
        dq_in = dq_oe ? dq_out : (drv ? rd : ~held);
    end
    always @(negedge clk) held <= dq_in;
    // ****************
    // Command front end
    // ****************
    always @(negedge clk or negedge pins.powerdown_reset_n) begin
        if (!pins.powerdown_reset_n) begin
            mode = 2'd0;
            pend = 2'd0;
            wr = 1'b0;
        end else if (!pins.write_n && !pins.chip_sel_n) begin
            wa = pins.addr;
            wd = dq_out;
            wr = 1'b1;
        end else if (wr) begin
            wr = 1'b0;
            lock = wa <= BOOT_LAST && !boot_unlock_level;
            if (pend == 2'd1) begin
                if (lock) sr[4] = 1'b1;
                else if (program_supply_high) mem[wa] = wd;
                mode = 2'd2;
                pend = 2'd0;
            end else if (pend == 2'd2) begin
                if (wd[7:0] != CMD_CONFIRM) sr[5:4] = 2'b11;
                else if (lock) sr[5] = 1'b1;
                mode = 2'd2;
                pend = 2'd0;
            end else begin
                case (wd[7:0])
                    CMD_RD_ARRAY: mode = 2'd0;
                    CMD_IDENT: mode = 2'd1;
                    CMD_RD_STAT: mode = 2'd2;
                    CMD_CLR_STAT: sr[5:4] = 2'b00;
                    CMD_PROG_SET, CMD_PROG_ALT: pend = 2'd1;
                    CMD_ERASE_SET: pend = 2'd2;
                    default: ;
                endcase
            end
        end
    end
endmodule : fbm_flash_model

// >>> sim/tb_top.sv
/* Self-checking bench for the flash host controller.
   Assumes the flash model resolves the shared data bus. */
`timescale 1ns/1ps
module tb_top;
    import fbm_pkg::*;
    localparam logic [15:0] MFR = 16'h00A5; // Arbitrary value
    localparam logic [15:0] DEV = 16'h00C3; // Arbitrary value
    logic              clk = 0, rst = 1, req_valid = 0, boot_unlock_req = 0, supply = 1;
    fbm_req_t          req_kind = REQ_READ;
    logic [17:0]       req_addr = '0;
    logic [15:0]       req_data = '0;
    wire               req_ready, rsp_valid, unlock_lvl, probe_lvl, dq_oe;
    wire  [15:0]       rsp_data, dq_out, dq_in;
    wire  fbm_pins_t   pins;
    int                bad_count = 0, num_checks = 0;
    always #10 clk = ~clk;
    fbm_host fbm_host_inst (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_kind(req_kind), .req_addr(req_addr), .req_data(req_data), .boot_unlock_req(boot_unlock_req),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins), .boot_unlock_level(unlock_lvl),
        .identifier_probe_level(probe_lvl), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
    fbm_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) fbm_flash_model_inst (.clk(clk), .pins(pins),
        .dq_out(dq_out), .dq_oe(dq_oe), .boot_unlock_level(unlock_lvl), .identifier_probe_level(probe_lvl),
        .program_supply_high(supply), .dq_in(dq_in));
    // ****************
    // Tasks
    // ****************
    task automatic finish_test;
        if (bad_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t: data %h expected %h", $time, got, exp);
        end
    endtask : chk16
    task automatic op(input fbm_req_t k, input logic [17:0] a, input logic [15:0] d, input logic [15:0] e);
        int n;
        req_kind = k;
        req_addr = a;
        req_data = d;
        req_valid = 1'b1;
        for (n = 0; req_ready !== 1'b1 && n < 50; n++) @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        for (n = 0; rsp_valid !== 1'b1 && n < 60; n++) @(negedge clk);
        if (n >= 60) chk16(16'hDEAD, 16'h0000);
        else if (k inside {REQ_READ, REQ_IDENT, REQ_PROBE_ID}) chk16(rsp_data, e);
    endtask : op
    // ****************
    // Tests
    // ****************
    initial begin
        repeat (2) @(negedge clk);
        rst = 0;
        repeat (2) @(negedge clk);
        op(REQ_READ, 18'h0_0005, 16'h0000, 16'hFFFF);
        op(REQ_IDENT, 18'h0_0000, 16'h0000, MFR);
        op(REQ_IDENT, 18'h0_0001, 16'h0000, DEV);
        op(REQ_READ, 18'h0_0001, 16'h0000, DEV);
        op(REQ_CMD, 18'h0_0000, 16'h00B0, 16'h0000);
        op(REQ_CMD, 18'h0_0000, 16'h00FF, 16'h0000);
        op(REQ_READ, 18'h0_0001, 16'h0000, 16'hFFFF);
        op(REQ_PROBE_ID, 18'h0_0001, 16'h0000, DEV);
        op(REQ_PROGRAM, 18'h0_2100, 16'h1234, 16'h0000);
        op(REQ_READ, 18'h1_2345, 16'h0000, 16'h0080);
        op(REQ_CMD, 18'h0_0000, 16'h00FF, 16'h0000);
        op(REQ_READ, 18'h0_2100, 16'h0000, 16'h1234);
        op(REQ_PROGRAM, 18'h0_0010, 16'h5A5A, 16'h0000);
        op(REQ_ERASE, 18'h0_0010, 16'h0000, 16'h0000);
        op(REQ_READ, 18'h0_0010, 16'h0000, 16'h00B0);
        op(REQ_CMD, 18'h0_0000, 16'h0050, 16'h0000);
        op(REQ_CMD, 18'h0_0000, 16'h0070, 16'h0000);
        op(REQ_READ, 18'h0_0333, 16'h0000, 16'h0080);
        op(REQ_CMD, 18'h0_0000, 16'h0020, 16'h0000);
        op(REQ_CMD, 18'h0_0000, 16'h0000, 16'h0000);
        op(REQ_READ, 18'h0_0000, 16'h0000, 16'h00B0);
        op(REQ_CMD, 18'h0_0000, 16'h0050, 16'h0000);
        supply = 0;
        op(REQ_PROGRAM, 18'h0_2200, 16'h5555, 16'h0000);
        op(REQ_CMD, 18'h0_0000, 16'h00FF, 16'h0000);
        op(REQ_READ, 18'h0_2200, 16'h0000, 16'hFFFF);
        supply = 1;
        boot_unlock_req = 1;
        op(REQ_PROGRAM, 18'h0_0010, 16'h5A5A, 16'h0000);
        op(REQ_CMD, 18'h0_2300, 16'h0010, 16'h0000);
        op(REQ_CMD, 18'h0_2300, 16'h0077, 16'h0000);
        op(REQ_CMD, 18'h0_0000, 16'h00FF, 16'h0000);
        op(REQ_READ, 18'h0_0010, 16'h0000, 16'h5A5A);
        op(REQ_READ, 18'h0_2300, 16'h0000, 16'h0077);
        finish_test();
    end
    initial begin
        #200000;
        bad_count++;
        finish_test();
    end
endmodule : tb_top
